// [src/addr_interrogation.sv]
`timescale 1ns/100ps
module addr_interrogation #(
  parameter int SLOT_W = 6
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  input  wire logic              trst_n,
  input  wire logic [SLOT_W-1:0] slot_addr,
  input  wire logic              tdo_line,
  output logic                   tdo_out,
  output logic                   tdo_oe,
  output logic                   tdo_weak,
  output bridge_pkg::sel_state_e sel_mode,
  output logic                   interrogating,
  output logic                   address_won
);
  import bridge_pkg::*;

  localparam logic [3:0] SLOT_CNT = 4'(SLOT_W);
  localparam int         PAD_W    = IR_W - SLOT_W;

  // Pin synchronisers into the test clock domain
  logic [1:0]        por_sync_ff;
  logic [1:0]        trst_sync_ff;
  logic [SLOT_W-1:0] slot_s1_ff;
  logic [SLOT_W-1:0] slot_s2_ff;
  logic              hard_rst;
  logic              lrst;

  always_ff @(posedge tck) begin
    por_sync_ff  <= {por_sync_ff[0], reset};
    trst_sync_ff <= {trst_sync_ff[0], ~trst_n};
    slot_s1_ff   <= slot_addr;
    slot_s2_ff   <= slot_s1_ff;
  end

  // Power-up and the reset pin need test clocks to take effect here
  assign hard_rst = por_sync_ff[1] | trst_sync_ff[1];

  tap_if tap_bus ();

  tap_fsm u_tap (
    .tck (tck),
    .rst (hard_rst),
    .tms (tms),
    .tap (tap_bus.ctrl)
  );

  assign lrst = hard_rst | tap_bus.tlr;

  // Keeps the state check quiet until a first reset has cleared the flops
  logic rst_seen_ff;
  logic nxt_rst_seen_ff;

  assign nxt_rst_seen_ff = rst_seen_ff | lrst;

  always_ff @(posedge tck) begin
    rst_seen_ff <= nxt_rst_seen_ff;
  end

  // Selector, shifter and line driver
  sel_state_e      state_ff;
  sel_state_e      nxt_state_ff;
  logic [IR_W-1:0] shreg_ff;
  logic [IR_W-1:0] nxt_shreg_ff;
  logic [IR_W-1:0] instr_ff;
  logic [IR_W-1:0] nxt_instr_ff;
  logic [IR_W-1:0] addr_ff;
  logic [IR_W-1:0] nxt_addr_ff;
  logic [3:0]      cnt_ff;
  logic [3:0]      nxt_cnt_ff;
  logic            oe_ff;
  logic            nxt_oe_ff;
  logic            out_ff;
  logic            nxt_out_ff;
  logic            weak_ff;
  logic            nxt_weak_ff;
  logic            won_ff;
  logic            nxt_won_ff;
  logic            intg_lvl_ff;
  logic            nxt_intg_lvl_ff;
  logic            wait_lvl_ff;
  logic            nxt_wait_lvl_ff;
  logic            intg_mode;
  logic            own_slot;
  logic            multi_hit;

  assign intg_mode = (state_ff == ST_INTERROG) || (state_ff == ST_LOST);
  assign own_slot  = (shreg_ff == {{PAD_W{1'b0}}, slot_s2_ff});
  assign multi_hit = (shreg_ff == BCAST_ADDR) || (shreg_ff[7:2] == MCAST_GROUP);

  always_comb begin
    nxt_state_ff = state_ff;
    nxt_shreg_ff = shreg_ff;
    nxt_instr_ff = instr_ff;
    nxt_addr_ff  = addr_ff;
    nxt_cnt_ff   = cnt_ff;
    nxt_oe_ff    = 1'b0;
    nxt_out_ff   = out_ff;
    nxt_weak_ff  = weak_ff;
    nxt_won_ff   = won_ff;

    if (tap_bus.capture_ir) begin
      nxt_cnt_ff = 4'h0;
      nxt_won_ff = 1'b0;
      if (intg_mode) begin
        nxt_shreg_ff = {{PAD_W{1'b1}}, ~slot_s2_ff};
      end else begin
        nxt_shreg_ff = CAPTURE_IDLE;
      end
    end

    if (tap_bus.shift_ir) begin
      nxt_shreg_ff = {tdi, shreg_ff[IR_W-1:1]};
      // A weak one pulled low by a peer means a peer with a one in this address bit wins
      if (oe_ff && (tdo_line != out_ff)) begin
        nxt_oe_ff    = 1'b0;
        nxt_state_ff = ST_LOST;
      end else if (state_ff == ST_INTERROG && cnt_ff < SLOT_CNT) begin
        nxt_oe_ff   = 1'b1;
        nxt_out_ff  = shreg_ff[0];
        nxt_weak_ff = shreg_ff[0];
        nxt_cnt_ff  = cnt_ff + 4'h1;
      end else if (state_ff == ST_INTERROG && cnt_ff == SLOT_CNT) begin
        nxt_won_ff = 1'b1;
      end
    end

    if (tap_bus.update_ir) begin
      nxt_instr_ff = shreg_ff;
      if (shreg_ff == SOFT_RESET_CMD) begin
        nxt_state_ff = ST_WAIT_ADDR;
        nxt_addr_ff  = '0;
        nxt_won_ff   = 1'b0;
      end else begin
        unique case (state_ff)
          ST_WAIT_ADDR: begin
            nxt_addr_ff = shreg_ff;
            if (shreg_ff == OP_INTERROG) begin
              nxt_state_ff = ST_INTERROG;
            end else if (own_slot) begin
              nxt_state_ff = ST_SINGLE;
            end else if (multi_hit) begin
              nxt_state_ff = ST_MULTI;
            end else begin
              nxt_state_ff = ST_UNSEL;
            end
          end
          ST_INTERROG, ST_LOST: begin
            if (shreg_ff != OP_INTERROG) begin
              nxt_state_ff = ST_WAIT_ADDR;
            end else if (won_ff && state_ff == ST_INTERROG) begin
              nxt_state_ff = ST_WAIT_RESET;
            end else begin
              nxt_state_ff = ST_INTERROG;
            end
          end
          ST_WAIT_RESET: begin
            nxt_state_ff = ST_WAIT_RESET;
          end
          ST_UNSEL, ST_SINGLE, ST_MULTI: begin
            if (shreg_ff == RETURN_TO_WAIT_CMD) begin
              nxt_state_ff = ST_WAIT_ADDR;
            end
          end
          default: begin
            nxt_state_ff = ST_WAIT_ADDR;
          end
        endcase
      end
    end

    nxt_intg_lvl_ff = (nxt_state_ff == ST_INTERROG) || (nxt_state_ff == ST_LOST);
    nxt_wait_lvl_ff = (nxt_state_ff == ST_WAIT_RESET);
  end

  always_ff @(posedge tck) begin
    if (lrst) begin
      state_ff    <= ST_WAIT_ADDR;
      shreg_ff    <= CAPTURE_IDLE;
      instr_ff    <= '0;
      addr_ff     <= '0;
      cnt_ff      <= 4'h0;
      oe_ff       <= 1'b0;
      out_ff      <= 1'b1;
      weak_ff     <= 1'b1;
      won_ff      <= 1'b0;
      intg_lvl_ff <= 1'b0;
      wait_lvl_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state_ff;
      shreg_ff    <= nxt_shreg_ff;
      instr_ff    <= nxt_instr_ff;
      addr_ff     <= nxt_addr_ff;
      cnt_ff      <= nxt_cnt_ff;
      oe_ff       <= nxt_oe_ff;
      out_ff      <= nxt_out_ff;
      weak_ff     <= nxt_weak_ff;
      won_ff      <= nxt_won_ff;
      intg_lvl_ff <= nxt_intg_lvl_ff;
      wait_lvl_ff <= nxt_wait_lvl_ff;
    end
  end

  assign tdo_out  = out_ff;
  assign tdo_oe   = oe_ff;
  assign tdo_weak = weak_ff;
  assign sel_mode = state_ff;

  // Status levels into the system clock domain; each bit crosses alone
  logic [1:0] intg_sync_ff;
  logic [1:0] wait_sync_ff;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      intg_sync_ff <= 2'h0;
      wait_sync_ff <= 2'h0;
    end else begin
      intg_sync_ff <= {intg_sync_ff[0], intg_lvl_ff};
      wait_sync_ff <= {wait_sync_ff[0], wait_lvl_ff};
    end
  end

  assign interrogating = intg_sync_ff[1];
  assign address_won   = wait_sync_ff[1];

  sel_onehot_a: assert property (
    @(posedge tck) disable iff (lrst || !rst_seen_ff) $onehot(state_ff))
    else $error("selector state not one-hot");

  idle_capture_a: assert property (
    @(posedge tck) disable iff (lrst)
    tap_bus.capture_ir && !intg_mode |=> shreg_ff[1:0] == 2'b01)
    else $error("idle capture did not load 01");

  enter_intg_a: assert property (
    @(posedge tck) disable iff (lrst)
    tap_bus.update_ir && state_ff == ST_WAIT_ADDR && shreg_ff == OP_INTERROG
    |=> state_ff == ST_INTERROG && addr_ff == OP_INTERROG)
    else $error("interrogation opcode not taken");

  inv_capture_a: assert property (
    @(posedge tck) disable iff (lrst)
    tap_bus.capture_ir && intg_mode |=> shreg_ff[SLOT_W-1:0] == ~$past(slot_s2_ff))
    else $error("inverted slot address not captured");

  lsb_first_a: assert property (
    @(posedge tck) disable iff (lrst)
    tap_bus.shift_ir && state_ff == ST_INTERROG && cnt_ff == 4'h0 && !oe_ff
    |=> oe_ff && out_ff == $past(shreg_ff[0]) && cnt_ff == 4'h1)
    else $error("first interrogation bit not the low bit");

  mismatch_a: assert property (
    @(posedge tck) disable iff (lrst)
    tap_bus.shift_ir && oe_ff && tdo_line != out_ff |=> !oe_ff && state_ff == ST_LOST)
    else $error("compare error did not release the line");

  win_a: assert property (
    @(posedge tck) disable iff (lrst)
    tap_bus.update_ir && won_ff && state_ff == ST_INTERROG && shreg_ff == OP_INTERROG
    |=> state_ff == ST_WAIT_RESET && !oe_ff)
    else $error("winner did not wait for reset");

  lost_quiet_a: assert property (
    @(posedge tck) disable iff (lrst) state_ff == ST_LOST |-> !oe_ff)
    else $error("beaten device drives the line");

  wait_quiet_a: assert property (
    @(posedge tck) disable iff (lrst)
    state_ff == ST_WAIT_RESET && !(tap_bus.update_ir && shreg_ff == SOFT_RESET_CMD)
    |=> !oe_ff && state_ff == ST_WAIT_RESET)
    else $error("device waiting for reset became active");

  weak_one_a: assert property (
    @(posedge tck) disable iff (lrst) oe_ff |-> weak_ff == out_ff)
    else $error("drive strength does not follow the bit");

  leave_intg_a: assert property (
    @(posedge tck) disable iff (lrst)
    tap_bus.update_ir && intg_mode && shreg_ff != OP_INTERROG
    && shreg_ff != SOFT_RESET_CMD |=> state_ff == ST_WAIT_ADDR)
    else $error("foreign opcode kept interrogation");

  bit_bound_a: assert property (
    @(posedge tck) disable iff (lrst) oe_ff |-> cnt_ff <= SLOT_CNT && cnt_ff != 4'h0)
    else $error("driving outside the address bits");

  retry_opcode_a: assert property (
    @(posedge tck) disable iff (lrst) state_ff == ST_INTERROG |-> instr_ff == OP_INTERROG)
    else $error("interrogation without a repeated opcode");

  line_release_a: assert property (
    @(posedge tck) disable iff (lrst) won_ff |-> !oe_ff)
    else $error("winner still drives the line");

  oe_release_a: assert property (
    @(posedge tck) disable iff (lrst) !tap_bus.shift_ir |=> !oe_ff)
    else $error("line driven outside Shift-IR");

  soft_reset_a: assert property (
    @(posedge tck) disable iff (lrst)
    tap_bus.update_ir && shreg_ff == SOFT_RESET_CMD |=> state_ff == ST_WAIT_ADDR)
    else $error("soft reset command ignored");

  select_one_a: assert property (
    @(posedge tck) disable iff (lrst)
    tap_bus.update_ir && state_ff == ST_WAIT_ADDR && shreg_ff != SOFT_RESET_CMD
    |=> state_ff == ST_UNSEL || state_ff == ST_SINGLE || state_ff == ST_MULTI
    || state_ff == ST_INTERROG)
    else $error("address-wait did not pick one selection");
endmodule

// [pkg/bridge_pkg.sv]
// How it works
// - From address-wait, any opcode but the soft reset command takes the selector to exactly one of unselected, single, multi or interrogation.
// - Outside interrogation, Capture-IR loads the instruction shifter with low bits 01.
// - An interrogation opcode taken at Update-IR is copied into the address register.
// - In interrogation, Capture-IR loads the inverted slot address into the shifter.
// - The inverted address leaves least significant bit first during Shift-IR.
// - Every driven bit is compared with the level seen on the shared data line.
// - A device that sends all its bits unbeaten releases the line and waits for reset at Update-IR.
// - A beaten device stays off the line and retries only if the opcode is repeated.
// - A device waiting for reset never drives the line again until it is reset.
// - A one is driven weakly and a zero strongly, so the line is a wired-AND.
// - The master sees the AND of all inverted addresses still being driven.
// - Any other opcode during interrogation returns the selector to address-wait.
// - Power-up, the test reset pin or five TMS-high clocks reset it all; the soft reset command just returns to address-wait and clears addr_ff and won_ff.
package bridge_pkg;
  localparam int         IR_W               = 8;
  localparam logic [7:0] OP_INTERROG        = 8'h3a;
  localparam logic [7:0] RETURN_TO_WAIT_CMD = 8'hc1;
  localparam logic [7:0] SOFT_RESET_CMD     = 8'hc2;
  localparam logic [7:0] BCAST_ADDR         = 8'h3b;
  localparam logic [5:0] MCAST_GROUP        = 6'h0f;
  localparam logic [7:0] CAPTURE_IDLE       = 8'h01;

  typedef enum logic [6:0] {
    ST_WAIT_ADDR  = 7'h01,
    ST_UNSEL      = 7'h02,
    ST_SINGLE     = 7'h04,
    ST_MULTI      = 7'h08,
    ST_INTERROG   = 7'h10,
    ST_LOST       = 7'h20,
    ST_WAIT_RESET = 7'h40
  } sel_state_e;

  typedef enum logic [15:0] {
    TAP_RESET    = 16'h0001,
    TAP_IDLE     = 16'h0002,
    TAP_DR_SEL   = 16'h0004,
    TAP_DR_CAP   = 16'h0008,
    TAP_DR_SHIFT = 16'h0010,
    TAP_DR_EXIT1 = 16'h0020,
    TAP_DR_PAUSE = 16'h0040,
    TAP_DR_EXIT2 = 16'h0080,
    TAP_DR_UPD   = 16'h0100,
    TAP_IR_SEL   = 16'h0200,
    TAP_IR_CAP   = 16'h0400,
    TAP_IR_SHIFT = 16'h0800,
    TAP_IR_EXIT1 = 16'h1000,
    TAP_IR_PAUSE = 16'h2000,
    TAP_IR_EXIT2 = 16'h4000,
    TAP_IR_UPD   = 16'h8000
  } tap_state_e;
endpackage

// [pkg/tap_if.sv]
`timescale 1ns/100ps
interface tap_if;
  logic tlr;
  logic capture_ir;
  logic shift_ir;
  logic update_ir;
  modport ctrl (output tlr, output capture_ir, output shift_ir, output update_ir);
  modport user (input tlr, input capture_ir, input shift_ir, input update_ir);
endinterface

// [src/tap_fsm.sv]
`timescale 1ns/100ps
module tap_fsm (
  input  wire logic tck,
  input  wire logic rst,
  input  wire logic tms,
  tap_if.ctrl       tap
);
  import bridge_pkg::*;

  tap_state_e state_ff;
  tap_state_e nxt_state_ff;

  always_comb begin
    unique case (state_ff)
      TAP_RESET:    nxt_state_ff = tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     nxt_state_ff = tms ? TAP_DR_SEL   : TAP_IDLE;
      TAP_DR_SEL:   nxt_state_ff = tms ? TAP_IR_SEL   : TAP_DR_CAP;
      TAP_DR_CAP:   nxt_state_ff = tms ? TAP_DR_EXIT1 : TAP_DR_SHIFT;
      TAP_DR_SHIFT: nxt_state_ff = tms ? TAP_DR_EXIT1 : TAP_DR_SHIFT;
      TAP_DR_EXIT1: nxt_state_ff = tms ? TAP_DR_UPD   : TAP_DR_PAUSE;
      TAP_DR_PAUSE: nxt_state_ff = tms ? TAP_DR_EXIT2 : TAP_DR_PAUSE;
      TAP_DR_EXIT2: nxt_state_ff = tms ? TAP_DR_UPD   : TAP_DR_SHIFT;
      TAP_DR_UPD:   nxt_state_ff = tms ? TAP_DR_SEL   : TAP_IDLE;
      TAP_IR_SEL:   nxt_state_ff = tms ? TAP_RESET    : TAP_IR_CAP;
      TAP_IR_CAP:   nxt_state_ff = tms ? TAP_IR_EXIT1 : TAP_IR_SHIFT;
      TAP_IR_SHIFT: nxt_state_ff = tms ? TAP_IR_EXIT1 : TAP_IR_SHIFT;
      TAP_IR_EXIT1: nxt_state_ff = tms ? TAP_IR_UPD   : TAP_IR_PAUSE;
      TAP_IR_PAUSE: nxt_state_ff = tms ? TAP_IR_EXIT2 : TAP_IR_PAUSE;
      TAP_IR_EXIT2: nxt_state_ff = tms ? TAP_IR_UPD   : TAP_IR_SHIFT;
      TAP_IR_UPD:   nxt_state_ff = tms ? TAP_DR_SEL   : TAP_IDLE;
      default:      nxt_state_ff = TAP_RESET;
    endcase
  end

  always_ff @(posedge tck) begin
    if (rst) begin
      state_ff <= TAP_RESET;
    end else begin
      state_ff <= nxt_state_ff;
    end
  end

  // Test-logic-reset doubles as the selector reset
  assign tap.tlr        = (state_ff == TAP_RESET);
  assign tap.capture_ir = (state_ff == TAP_IR_CAP);
  assign tap.shift_ir   = (state_ff == TAP_IR_SHIFT);
  assign tap.update_ir  = (state_ff == TAP_IR_UPD);

  tms_reset_a: assert property (
    @(posedge tck) disable iff (rst) tms [*5] |=> tap.tlr)
    else $error("five TMS-high clocks did not reach reset");
endmodule

// [verif/peer_bridge.sv]
`timescale 1ns/100ps
module peer_bridge #(
  parameter int SLOT_W = 6
) (
  input  wire logic              tck,
  input  wire logic              clr,
  input  wire logic              en,
  input  wire logic              go,
  input  wire logic [SLOT_W-1:0] inv_addr,
  input  wire logic              line,
  output logic                   drv_out,
  output logic                   drv_oe
);
  logic [3:0] cnt;
  logic       won;

  // Same one-edge lag as the device, so both compare on the same edge
  always_ff @(posedge tck) begin
    if (clr) begin
      won     <= 1'b0;
      drv_oe  <= 1'b0;
      drv_out <= 1'b1;
      cnt     <= 4'h0;
    end else if (!go) begin
      cnt    <= 4'h0;
      drv_oe <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'h0) begin
        drv_oe  <= en && !won;
        drv_out <= inv_addr[0];
      end else if (drv_oe && line !== drv_out) begin
        drv_oe <= 1'b0;
      end else if (drv_oe && cnt < SLOT_W) begin
        drv_out <= inv_addr[cnt];
      end else if (drv_oe) begin
        drv_oe <= 1'b0;
        won    <= 1'b1;
      end
    end
  end
endmodule

// [verif/test_multidrop_address_interrogation.sv]
`timescale 1ns/100ps
module test_multidrop_address_interrogation;
  import bridge_pkg::*;
  localparam int SW = 6;
  logic          ref_clk;
  logic          reset;
  logic          tck;
  logic          tms;
  logic          tdi;
  logic          trst_n;
  logic [SW-1:0] slot_addr;
  logic          tdo_line;
  logic          tdo_out;
  logic          tdo_oe;
  logic          tdo_weak;
  sel_state_e    sel_mode;
  logic          interrogating;
  logic          address_won;
  logic          p_clr;
  logic          p_en;
  logic          p_go;
  logic [SW-1:0] p_inv;
  logic          p_out;
  logic          p_oe;
  int            mismatches;
  int            total_checks;

  always #12.5 ref_clk = ~ref_clk;
  always #3 tck = ~tck;

  addr_interrogation #(.SLOT_W(SW)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .slot_addr(slot_addr), .tdo_line(tdo_line),
    .tdo_out(tdo_out), .tdo_oe(tdo_oe), .tdo_weak(tdo_weak), .sel_mode(sel_mode),
    .interrogating(interrogating), .address_won(address_won)
  );

  peer_bridge #(.SLOT_W(SW)) peer_u (
    .tck(tck), .clr(p_clr), .en(p_en), .go(p_go), .inv_addr(p_inv),
    .line(tdo_line), .drv_out(p_out), .drv_oe(p_oe)
  );

  // Pull-up gives a weak one when nobody drives
  assign tdo_line = (tdo_oe ? tdo_out : 1'b1) & (p_oe ? p_out : 1'b1);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic tap(input logic m);
    @(posedge tck);
    #1;
    tms = m;
  endtask

  // Line is read one edge late because the device output lags by one tck
  task automatic ir_scan(input logic [7:0] op, output logic [7:0] seen);
    tap(1'b1);
    tap(1'b1);
    tap(1'b0);
    tap(1'b0);
    for (int i = 0; i < 9; i++) begin
      @(posedge tck);
      #1;
      if (i > 0) seen[i-1] = tdo_line;
      if (i > 0 && tdo_oe === 1'b1) check({7'h00, tdo_weak}, {7'h00, tdo_out});
      tms  = (i >= 7);
      tdi  = op[i%8];
      p_go = (i <= SW);
    end
    tap(1'b0);
    tap(1'b0);
    tap(1'b0);
  endtask

  function automatic logic [7:0] arb(input logic [SW-1:0] a, input logic [SW-1:0] b,
                                     input logic ea, input logic eb);
    logic [7:0] r;
    r = 8'hff;
    for (int k = 0; k < SW; k++) begin
      r[k] = (ea ? a[k] : 1'b1) & (eb ? b[k] : 1'b1);
      ea   = ea && (a[k] == r[k]);
      eb   = eb && (b[k] == r[k]);
    end
    return r;
  endfunction

  task automatic apply_reset(input int k);
    logic [7:0] d;
    if (k == 0) begin
      @(posedge ref_clk);
      #1;
      reset = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      reset = 1'b0;
    end else if (k == 1) begin
      @(posedge tck);
      #1;
      trst_n = 1'b0;
      repeat (6) @(posedge tck);
      #1;
      trst_n = 1'b1;
    end else if (k == 2) begin
      repeat (5) tap(1'b1);
    end else begin
      ir_scan(SOFT_RESET_CMD, d);
    end
    repeat (4) tap(1'b0);
  endtask

  initial begin
    logic [7:0]    seen;
    logic [7:0]    exp;
    logic [7:0]    op;
    logic [SW-1:0] da;
    logic [SW-1:0] pa;
    logic          din;
    logic          pin;
    int unsigned   rnd;
    ref_clk      = 1'b0;
    tck          = 1'b0;
    reset        = 1'b1;
    trst_n       = 1'b1;
    tms          = 1'b1;
    tdi          = 1'b0;
    slot_addr    = 6'h01;
    p_clr        = 1'b1;
    p_en         = 1'b0;
    p_go         = 1'b0;
    p_inv        = 6'h3f;
    mismatches   = 0;
    total_checks = 0;
    rnd = $urandom(32'h562f);
    repeat (3) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    for (int r = 0; r < 8; r++) begin
      // Slots 3a-3f would decode as opcodes in the select scan
      da = SW'($urandom_range(1, 'h39));
      pa = SW'($urandom_range(1, 2 ** SW - 1));
      if (r == 0) da = 6'h01;
      if (r == 0) pa = 6'h14;
      if (r == 1) da = 6'h20;
      if (r == 1) pa = 6'h3f;
      if (pa == da) pa = (da == 6'h01) ? 6'h02 : 6'h01;
      slot_addr = da;
      p_inv     = ~pa;
      apply_reset(r % 4);
      check({1'b0, sel_mode}, {1'b0, ST_WAIT_ADDR});
      repeat (4) @(posedge ref_clk);
      #1;
      check({6'h00, interrogating, address_won}, 8'h00);
      op  = 8'h00;
      exp = {1'b0, ST_UNSEL};
      if (r % 4 == 0) begin
        op  = {2'b00, da};
        exp = {1'b0, ST_SINGLE};
      end else if (r % 4 != 3) begin
        op  = (r % 4 == 1) ? BCAST_ADDR : {MCAST_GROUP, 2'(r)};
        exp = {1'b0, ST_MULTI};
      end
      ir_scan(op, seen);
      check({1'b0, sel_mode}, exp);
      ir_scan(RETURN_TO_WAIT_CMD, seen);
      check({1'b0, sel_mode}, {1'b0, ST_WAIT_ADDR});
      ir_scan(OP_INTERROG, seen);
      check({1'b0, sel_mode}, {1'b0, ST_INTERROG});
      if (r % 2 == 1) begin
        op = 8'($urandom_range(0, 255));
        if (op == OP_INTERROG) op = RETURN_TO_WAIT_CMD;
        ir_scan(op, seen);
        check({1'b0, sel_mode}, {1'b0, ST_WAIT_ADDR});
        ir_scan(OP_INTERROG, seen);
      end
      repeat (4) @(posedge ref_clk);
      #1;
      check({7'h00, interrogating}, 8'h01);
      tap(1'b0);
      p_clr = 1'b0;
      p_en  = 1'b1;
      din   = 1'b1;
      pin   = 1'b1;
      for (int n = 0; n < 4 && (din || pin); n++) begin
        exp = arb(~da, ~pa, din, pin);
        ir_scan(OP_INTERROG, seen);
        check(seen, exp);
        if (din && exp[SW-1:0] == ~da) begin
          check({1'b0, sel_mode}, {1'b0, ST_WAIT_RESET});
          din = 1'b0;
        end else if (din) begin
          check({1'b0, sel_mode}, {1'b0, ST_INTERROG});
        end else begin
          check({1'b0, sel_mode}, {1'b0, ST_WAIT_RESET});
        end
        if (pin && exp[SW-1:0] == ~pa) pin = 1'b0;
      end
      if (din || pin) begin
        mismatches++;
        $display("CHECK FAILED at %0t: arbitration did not finish", $time);
        break;
      end
      ir_scan(OP_INTERROG, seen);
      check(seen, 8'hff);
      ir_scan(RETURN_TO_WAIT_CMD, seen);
      check({1'b0, sel_mode}, {1'b0, ST_WAIT_RESET});
      repeat (4) @(posedge ref_clk);
      #1;
      check({7'h00, address_won}, 8'h01);
      p_en  = 1'b0;
      p_clr = 1'b1;
      $display("Round %0d done: slot %h peer %h", r, da, pa);
    end
    report_and_stop();
  end
endmodule
